// ### src/btob_exec.v
/*
 * btob_exec.v - decode and execute of the bit-toggle, branch-on-overflow
 * and bit-test-and-skip instructions, one instruction cycle being four
 * clocks (Q1 decode, Q2 read, Q3 process, Q4 write).
 * Assumes: fetch presents instr_word and pc_plus2 (address of the next
 * word) for the whole of Q1; data memory answers rd_data combinationally
 * while dm_rd_ff is high; next_two_word tells, by Q2, whether the
 * prefetched instruction is a two-word one.
 */
`include "btob_consts.vh"

module btob_exec
#(
	parameter PC_W = 21
)
(
	input  wire            clk,
	input  wire            resetn,
	input  wire [15:0]     instr_word,
	input  wire [PC_W-1:0] pc_plus2,
	input  wire            overflow_flag,
	input  wire [3:0]      bank_select_register,
	input  wire [7:0]      rd_data,
	input  wire            next_two_word,
	output wire [3:0]      q_phase,
	output reg  [11:0]     dm_addr_ff,
	output reg             dm_rd_ff,
	output reg             dm_we_ff,
	output reg  [7:0]      dm_wdata_ff,
	output reg             pc_load_ff,
	output reg  [PC_W-1:0] pc_target_ff,
	output reg             idle_cycle_ff
);

	// one-hot operation codes held for the current instruction cycle
	localparam [4:0] OP_NONE   = 5'h01;
	localparam [4:0] OP_TOGGLE = 5'h02;
	localparam [4:0] OP_BRANCH = 5'h04;
	localparam [4:0] OP_SKIPC  = 5'h08;
	localparam [4:0] OP_SKIPS  = 5'h10;

	wire            in_q1;
	wire            in_q2;
	wire            in_q3;
	wire            in_q4;
	reg  [4:0]      nxt_op;
	reg  [4:0]      op_ff;
	reg  [15:0]     ir_ff;
	reg  [PC_W-1:0] pc_inc_ff;
	reg  [7:0]      data_ff;
	reg             ovf_ff;
	reg             two_word_ff;
	reg             skip_ff;
	reg  [1:0]      idle_cnt_ff;
	reg  [1:0]      nxt_idle;
	reg  [3:0]      bank;
	reg  [7:0]      bit_mask;
	wire [PC_W-1:0] offset2;

	// ======================================================================
	// quarter-cycle sequencing
	// ======================================================================
	btob_qphase u_qphase
	(
		.clk    (clk),
		.resetn (resetn),
		.q_ff   (q_phase)
	);

	assign in_q1 = (q_phase == `BTOB_Q1);
	assign in_q2 = (q_phase == `BTOB_Q2);
	assign in_q3 = (q_phase == `BTOB_Q3);
	assign in_q4 = (q_phase == `BTOB_Q4);

	// ======================================================================
	// decode
	// ======================================================================
	// a pending idle cycle swallows the prefetched word whatever it is
	always @*
	begin
		nxt_op = OP_NONE;
		if (idle_cnt_ff != `BTOB_IDLE_NONE)
			nxt_op = OP_NONE;
		else if (instr_word[`BTOB_OPC_HI:`BTOB_OPC_LO] == `BTOB_OPC_TOGGLE)
			nxt_op = OP_TOGGLE;
		else if (instr_word[`BTOB_BR_HI:`BTOB_BR_LO] == `BTOB_BR_OVF)
			nxt_op = OP_BRANCH;
		else if (instr_word[`BTOB_OPC_HI:`BTOB_OPC_LO] == `BTOB_OPC_SKIP_CLR)
			nxt_op = OP_SKIPC;
		else if (instr_word[`BTOB_OPC_HI:`BTOB_OPC_LO] == `BTOB_OPC_SKIP_SET)
			nxt_op = OP_SKIPS;
	end

	// instruction capture at the end of q1
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_ff     <= OP_NONE;
			ir_ff     <= 16'h0000;
			pc_inc_ff <= `BTOB_RST_PC;
		end
		else if (in_q1)
		begin
			op_ff     <= nxt_op;
			ir_ff     <= instr_word;
			pc_inc_ff <= pc_plus2;
		end
	end

	// ======================================================================
	// operand address
	// ======================================================================
	// bank resolution
	always @*
	begin
		bank = bank_select_register;
		if (!instr_word[`BTOB_ACC_POS])
		begin
			if (instr_word[`BTOB_FILE_HI:`BTOB_FILE_LO] < `BTOB_ACC_SPLIT)
				bank = `BTOB_ACC_LO_BANK;
			else
				bank = `BTOB_ACC_HI_BANK;
		end
	end

	// address and read strobe stand for the whole of q2
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dm_addr_ff <= `BTOB_RST_ADDR;
			dm_rd_ff   <= 1'b0;
		end
		else if (in_q1)
		begin
			dm_addr_ff <= {bank, instr_word[`BTOB_FILE_HI:`BTOB_FILE_LO]};
			dm_rd_ff   <= (nxt_op == OP_TOGGLE) || (nxt_op == OP_SKIPC) ||
				(nxt_op == OP_SKIPS);
		end
		else
			dm_rd_ff <= 1'b0;
	end

	// ======================================================================
	// read and process
	// ======================================================================
	// one-hot mask of the selected bit
	always @*
	begin
		bit_mask = 8'h01 << ir_ff[`BTOB_BIT_HI:`BTOB_BIT_LO];
	end

	// read data and flags are sampled at the end of q2
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			data_ff     <= `BTOB_RST_DATA;
			ovf_ff      <= 1'b0;
			two_word_ff <= 1'b0;
		end
		else if (in_q2)
		begin
			data_ff     <= rd_data;
			ovf_ff      <= overflow_flag;
			two_word_ff <= next_two_word;
		end
	end

	assign offset2 = {{(PC_W-9){ir_ff[7]}}, ir_ff[7:0], 1'b0};

	// ======================================================================
	// q4 write-back and program counter load
	// ======================================================================
	// strobes are raised at the end of q3 so they stand exactly during q4
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dm_we_ff     <= 1'b0;
			dm_wdata_ff  <= `BTOB_RST_DATA;
			pc_load_ff   <= 1'b0;
			pc_target_ff <= `BTOB_RST_PC;
			skip_ff      <= 1'b0;
		end
		else if (in_q3)
		begin
			dm_wdata_ff <= data_ff ^ bit_mask;
			dm_we_ff    <= (op_ff == OP_TOGGLE);
			pc_target_ff <= pc_inc_ff + offset2;
			pc_load_ff  <= (op_ff == OP_BRANCH) && ovf_ff;
			// skip test on the read bit
			skip_ff     <= ((op_ff == OP_SKIPC) && !(|(data_ff & bit_mask))) ||
				((op_ff == OP_SKIPS) && (|(data_ff & bit_mask)));
		end
		else
		begin
			dm_we_ff   <= 1'b0;
			pc_load_ff <= 1'b0;
			skip_ff    <= 1'b0;
		end
	end

	// ======================================================================
	// idle cycle insertion
	// ======================================================================
	// idle cycles are counted at the end of q4 of the instruction
	always @*
	begin
		nxt_idle = idle_cnt_ff;
		if (in_q4)
		begin
			// taken branch adds one idle cycle
			if (pc_load_ff)
				nxt_idle = `BTOB_IDLE_BRANCH;
			// skip over one or two words
			else if (skip_ff)
				nxt_idle = two_word_ff ? `BTOB_IDLE_SKIP2 : `BTOB_IDLE_SKIP1;
			else if (idle_cnt_ff != `BTOB_IDLE_NONE)
				nxt_idle = idle_cnt_ff - 2'h1;
		end
	end

	// idle flag covers the whole instruction cycle being discarded
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			idle_cnt_ff   <= `BTOB_IDLE_NONE;
			idle_cycle_ff <= 1'b0;
		end
		else
		begin
			idle_cnt_ff <= nxt_idle;
			if (in_q4)
				idle_cycle_ff <= (nxt_idle != `BTOB_IDLE_NONE);
		end
	end

endmodule // btob_exec

// ### src/btob_consts.vh
/*
 * btob_consts.vh - constants of the bit-toggle / overflow-branch / skip
 * execute logic: opcode fields, quarter-cycle codes, idle costs, widths.
 * Assumes it is included by bare name from each design file.
 */
`ifndef BTOB_CONSTS_VH
`define BTOB_CONSTS_VH

// ======================================================================
// opcode fields
// ======================================================================
`define BTOB_OPC_HI          15
`define BTOB_OPC_LO          12
`define BTOB_BIT_HI          11
`define BTOB_BIT_LO          9
`define BTOB_ACC_POS         8
`define BTOB_FILE_HI         7
`define BTOB_FILE_LO         0
`define BTOB_BR_HI           15
`define BTOB_BR_LO           8
`define BTOB_OPC_TOGGLE      4'h7
`define BTOB_OPC_SKIP_CLR    4'hb
`define BTOB_OPC_SKIP_SET    4'ha
`define BTOB_BR_OVF          8'he4

// ======================================================================
// banking
// ======================================================================
`define BTOB_ACC_SPLIT       8'h80
`define BTOB_ACC_LO_BANK     4'h0
`define BTOB_ACC_HI_BANK     4'hf

// ======================================================================
// quarter-cycle one-hot codes
// ======================================================================
`define BTOB_Q1              4'h1
`define BTOB_Q2              4'h2
`define BTOB_Q3              4'h4
`define BTOB_Q4              4'h8

// ======================================================================
// idle cycles inserted after an instruction
// ======================================================================
`define BTOB_IDLE_NONE       2'h0
`define BTOB_IDLE_BRANCH     2'h1
`define BTOB_IDLE_SKIP1      2'h1
`define BTOB_IDLE_SKIP2      2'h2

// ======================================================================
// reset values
// ======================================================================
`define BTOB_RST_ADDR        12'h000
`define BTOB_RST_DATA        8'h00
`define BTOB_RST_PC          21'h000000

`endif

// ### src/btob_qphase.v
/*
 * btob_qphase.v - quarter-cycle sequencer: a one-hot ring Q1..Q4 that
 * splits each instruction cycle into four core clocks.
 * Assumes a free-running clock and an asynchronous active-low reset.
 */
`include "btob_consts.vh"

module btob_qphase
(
	input  wire       clk,
	input  wire       resetn,
	output reg  [3:0] q_ff
);

	localparam [3:0] ST_Q1 = `BTOB_Q1;
	localparam [3:0] ST_Q2 = `BTOB_Q2;
	localparam [3:0] ST_Q3 = `BTOB_Q3;
	localparam [3:0] ST_Q4 = `BTOB_Q4;

	reg [3:0] nxt_q;

	// ======================================================================
	// ring advance
	// ======================================================================
	// a corrupted code falls back to q1 so the ring always recovers
	always @*
	begin
		case (q_ff)
			ST_Q1:   nxt_q = ST_Q2;
			ST_Q2:   nxt_q = ST_Q3;
			ST_Q3:   nxt_q = ST_Q4;
			ST_Q4:   nxt_q = ST_Q1;
			default: nxt_q = ST_Q1;
		endcase
	end

	// phase register
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q_ff <= ST_Q1;
		else
			q_ff <= nxt_q;
	end

endmodule // btob_qphase

// ### dv/btob_exec_props.sv
/* checker for the btob_exec ports.
   assumes it is bound onto btob_exec, one clock domain. */
module btob_exec_props #(parameter PC_W = 21)
(
	input logic            clk,
	input logic            resetn,
	input logic [15:0]     instr_word,
	input logic [PC_W-1:0] pc_plus2,
	input logic            overflow_flag,
	input logic [3:0]      bank_select_register,
	input logic [7:0]      rd_data,
	input logic            next_two_word,
	input logic [3:0]      q_phase,
	input logic [11:0]     dm_addr_ff,
	input logic            dm_rd_ff,
	input logic            dm_we_ff,
	input logic [7:0]      dm_wdata_ff,
	input logic            pc_load_ff,
	input logic [PC_W-1:0] pc_target_ff,
	input logic            idle_cycle_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// a word counts only at the end of a Q1 that is not idle
	wire take = q_phase == 4'h1 && !idle_cycle_ff;
	wire tog = take && instr_word[15:12] == 4'h7;
	sequence s_br;
		take && instr_word[15:8] == 8'he4;
	endsequence
	// skip decided in Q2 from the addressed bit
	sequence s_skip(t);
		take && instr_word[15:13] == 3'b101
		##1 rd_data[$past(instr_word[11:9])] != $past(instr_word[12]) && next_two_word == t;
	endsequence
	chk_toggle_walk: assert property (tog |-> ##1 dm_rd_ff ##2 dm_we_ff ##1 !dm_we_ff)
		else $error("toggle walk");
	chk_toggle_mask: assert property (dm_we_ff |->
		dm_wdata_ff == ($past(rd_data, 2) ^ (8'h1 << $past(instr_word[11:9], 3))))
		else $error("toggle data");
	chk_bank_addr: assert property (tog |=> dm_addr_ff == {$past(instr_word[8]) ?
		$past(bank_select_register) : {4{$past(instr_word[7])}}, $past(instr_word[7:0])})
		else $error("bank address");
	chk_branch_target: assert property (pc_load_ff |-> pc_target_ff == $past(pc_plus2, 3)
		+ {{(PC_W-9){$past(instr_word[7], 3)}}, $past(instr_word[7:0], 3), 1'b0})
		else $error("branch target");
	chk_branch_taken: assert property (s_br ##1 overflow_flag |-> ##2 pc_load_ff ##1
		idle_cycle_ff [*4])
		else $error("taken branch");
	chk_branch_not: assert property (s_br ##1 !overflow_flag |-> ##2 !pc_load_ff ##1
		!idle_cycle_ff)
		else $error("untaken branch");
	chk_skip_one: assert property (s_skip(1'b0) |-> ##3 idle_cycle_ff [*4] ##1 !idle_cycle_ff)
		else $error("skip one");
	chk_skip_two: assert property (s_skip(1'b1) |-> ##3 idle_cycle_ff [*8])
		else $error("skip two");
endmodule // btob_exec_props

bind btob_exec btob_exec_props #(.PC_W(PC_W)) u_props (.clk(clk), .resetn(resetn),
	.instr_word(instr_word), .pc_plus2(pc_plus2), .overflow_flag(overflow_flag),
	.bank_select_register(bank_select_register), .rd_data(rd_data),
	.next_two_word(next_two_word), .q_phase(q_phase), .dm_addr_ff(dm_addr_ff),
	.dm_rd_ff(dm_rd_ff), .dm_we_ff(dm_we_ff), .dm_wdata_ff(dm_wdata_ff),
	.pc_load_ff(pc_load_ff), .pc_target_ff(pc_target_ff), .idle_cycle_ff(idle_cycle_ff));

// ### dv/btob_dmem.sv
/* banked data memory model, 4096 bytes.
   assumes reads are answered at once while the read strobe is high. */
module btob_dmem
(
	input  wire        clk,
	input  wire [11:0] addr,
	input  wire        rd,
	input  wire        we,
	input  wire [7:0]  wdata,
	output logic [7:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:4095];
	logic [7:0] last_ff = 8'h00;
	// a pattern that differs from byte to byte
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ i[11:4];
	// unselected, show the inverse so stale data never passes
	assign rdata = rd ? mem[addr] : ~last_ff;
	always @(posedge clk)
	begin
		if (rd) last_ff <= mem[addr];
		if (we) mem[addr] <= wdata;
	end
endmodule // btob_dmem

// ### dv/btob_exec_tb.sv
/* self-checking bench for btob_exec.
   assumes btob_dmem as data memory; the bench plays fetch. */
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin n_fail++; \
	$display("Error %s exp %h got %h", nm, e, g); end end
module btob_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, resetn = 0, ovf = 0, two = 0, rd, we, pl, idl;
	logic [15:0] iw = 0;
	logic [20:0] pc2 = 0, tgt;
	logic [3:0] bank_sel = 0, q;
	logic [7:0] rdat, wd;
	logic [11:0] ad;
	logic [23:0] notes [$], e_v;
	int n_fail = 0, tests_run = 0, cyc = 0;
	always #10 clk = ~clk;
	btob_exec #(.PC_W(21)) DUT (.clk(clk), .resetn(resetn), .instr_word(iw), .pc_plus2(pc2),
		.overflow_flag(ovf), .bank_select_register(bank_sel), .rd_data(rdat),
		.next_two_word(two), .q_phase(q), .dm_addr_ff(ad), .dm_rd_ff(rd), .dm_we_ff(we),
		.dm_wdata_ff(wd), .pc_load_ff(pl), .pc_target_ff(tgt), .idle_cycle_ff(idl));
	btob_dmem u_mem (.clk(clk), .addr(ad), .rd(rd), .we(we), .wdata(wd), .rdata(rdat));
	task automatic print_verdict();
		$display("tests_run %0d n_fail %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// each end of Q4 is compared with the oldest note; cycle ceiling cuts a hang
	always @(posedge clk)
	begin
		cyc++;
		if (resetn && q === 4'h8)
		begin
			e_v = notes.size() ? notes.pop_front() : 24'hffffff;
			`CHK("cycle", e_v, {we, pl, idl, we ? {1'b0, ad, wd} : pl ? tgt : 21'h0})
		end
		// the ceiling check stands last so nothing runs after the verdict
		if (cyc > 2000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	function automatic [11:0] ea(input [15:0] w);
		ea = {w[8] ? bank_sel : {4{w[7]}}, w[7:0]};
	endfunction
	// one instruction cycle, then any idle ones with junk words
	task automatic op(input [15:0] w, input [23:0] nt, input int nidle);
		iw = w;
		notes.push_back(nt);
		repeat (4) @(negedge clk);
		repeat (nidle)
		begin
			iw = $urandom;
			notes.push_back(24'h200000);
			repeat (4) @(negedge clk);
		end
	endtask
	initial
	begin
		logic [15:0] w;
		logic [7:0] n;
		void'($urandom(32'hac1b));
		repeat (8) @(negedge clk);
		resetn = 1;
		for (int i = 0; i < 16; i++)
		begin
			bank_sel = $urandom;
			w = {4'h7, i[2:0], i[3], i[1], 7'($urandom)};
			op(w, {4'b1000, ea(w), u_mem.mem[ea(w)] ^ (8'h1 << i[2:0])}, 0);
		end
		$display("toggle test done");
		for (int i = 0; i < 6; i++)
		begin
			n = i < 2 ? 8'h80 : i < 4 ? 8'h7f : 8'($urandom);
			ovf = i[0];
			pc2 = 21'({$urandom, 1'b0});
			op({8'he4, n}, ovf ? {3'b010, pc2 + {{12{n[7]}}, n, 1'b0}} : 24'h0, ovf);
		end
		$display("branch test done");
		for (int i = 0; i < 8; i++)
		begin
			two = i[2];
			bank_sel = $urandom;
			w = {3'b101, i[0], 3'd0, 9'($urandom)};
			for (int k = 0; k < 8; k++)
				if (u_mem.mem[ea(w)][k] === i[1]) w[11:9] = k[2:0];
			n = u_mem.mem[ea(w)];
			op(w, 24'h0, n[w[11:9]] != i[0] ? 1 + two : 0);
		end
		$display("skip test done");
		for (int i = 0; i < 6; i++)
		begin
			w = $urandom;
			if (w[15:12] inside {4'h7, 4'ha, 4'hb} || w[15:8] == 8'he4) w[15:12] = 4'h0;
			op(w, 24'h0, 0);
		end
		`CHK("drained", 0, notes.size())
		$display("refused test done");
		print_verdict();
	end
endmodule // btob_exec_tb
